//--- include/osccs_pkg.sv
// Package for the oscillator control and status register block.
// Assumes a 32-bit AXI4-Lite slave port and 8-bit registers in the low lane.
package osccs_pkg;
  // Byte offsets of the registers
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK = 4'hC;

  // Control register fields
  localparam int FREQ_LSB = 3;
  localparam int FREQ_MSB = 6;
  localparam int CLKSEL_LSB = 0;
  localparam int CLKSEL_MSB = 1;
  localparam logic [3:0] FREQ_RESET = 4'h7;
  localparam logic [1:0] CLKSEL_RESET = 2'h0;

  // Interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_HF = 1;
  localparam int IRQ_LF = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {OSCCS_SRC_HF, OSCCS_SRC_LF} osccs_src_t;

  typedef struct packed {
    logic [3:0] freq;
    logic [1:0] clk_sel;
  } osccs_ctrl_t;

  typedef struct packed {
    logic hf_ready;
    logic lf_ready;
    logic hf_stable;
  } osccs_stat_t;

  // Only codes 000x run from the low-frequency oscillator
  function automatic osccs_src_t src_of(input logic [3:0] code);
    return (code[3:1] == 3'h0) ? OSCCS_SRC_LF : OSCCS_SRC_HF;
  endfunction

  // Power-of-two divide applied to the 16 MHz oscillator
  function automatic logic [3:0] div_exp(input logic [3:0] code);
    case (code)
      4'hF: return 4'h0;
      4'hE: return 4'h1;
      4'hD: return 4'h2;
      4'hC: return 4'h3;
      4'hB: return 4'h4;
      4'hA, 4'h7: return 4'h5;
      4'h9, 4'h6: return 4'h6;
      4'h8, 4'h5: return 4'h7;
      4'h4: return 4'h8;
      4'h3, 4'h2: return 4'h9;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] ctrl_byte(input osccs_ctrl_t c);
    return {1'b0, c.freq, 1'b0, c.clk_sel};
  endfunction

  function automatic logic [7:0] stat_byte(input osccs_stat_t s);
    return {3'h0, s.hf_ready, 2'h0, s.lf_ready, s.hf_stable};
  endfunction
endpackage

//--- verilog/osccs_switch.sv
// Internal oscillator switch sequencer.
// Assumes oscillator ready flags and clock levels are sampled on CLK_SYS.
`timescale 1ns/10ps
module osccs_switch (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] freq_req,
  input wire logic hf_rdy,
  input wire logic lf_rdy,
  input wire logic hf_lvl,
  input wire logic lf_lvl,
  output logic [3:0] active_code_q,
  output logic busy,
  output logic hold_low_q,
  output logic done_q,
  output logic hf_en,
  output logic lf_en
);
  typedef enum logic [2:0] {
    SW_IDLE, SW_START, SW_FALL, SW_HOLD, SW_DONE
  } osccs_sw_t;

  osccs_sw_t state_q;
  logic [3:0] target_q;
  logic hf_prev_q;
  logic lf_prev_q;
  osccs_pkg::osccs_src_t cur_src;
  osccs_pkg::osccs_src_t new_src;
  logic cur_fall;
  logic new_rise;
  logic new_rdy;

  assign cur_src = osccs_pkg::src_of(active_code_q);
  assign new_src = osccs_pkg::src_of(target_q);
  assign new_rdy = (new_src == osccs_pkg::OSCCS_SRC_HF) ? hf_rdy : lf_rdy;
  assign cur_fall = (cur_src == osccs_pkg::OSCCS_SRC_HF) ?
                    (hf_prev_q & ~hf_lvl) : (lf_prev_q & ~lf_lvl);
  assign new_rise = (new_src == osccs_pkg::OSCCS_SRC_HF) ?
                    (~hf_prev_q & hf_lvl) : (~lf_prev_q & lf_lvl);
  assign busy = (state_q != SW_IDLE);
  // The target source is started as soon as a switch to it begins
  assign hf_en = (cur_src == osccs_pkg::OSCCS_SRC_HF) ||
                 (busy && new_src == osccs_pkg::OSCCS_SRC_HF); // [R10]
  assign lf_en = (cur_src == osccs_pkg::OSCCS_SRC_LF) ||
                 (busy && new_src == osccs_pkg::OSCCS_SRC_LF);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hf_prev_q <= 1'b0;
      lf_prev_q <= 1'b0;
    end else begin
      hf_prev_q <= hf_lvl;
      lf_prev_q <= lf_lvl;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SW_IDLE;
      target_q <= osccs_pkg::FREQ_RESET;
      active_code_q <= osccs_pkg::FREQ_RESET;
      hold_low_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        SW_IDLE: begin
          if (freq_req != active_code_q) begin
            target_q <= freq_req;
            if (osccs_pkg::src_of(freq_req) == cur_src) begin
              // Same source: only the divider changes, no start-up wait
              active_code_q <= freq_req; // [R11]
              done_q <= 1'b1;
            end else begin
              state_q <= SW_START;
            end
          end
        end
        SW_START: if (new_rdy) state_q <= SW_FALL; // [R10]
        SW_FALL: begin
          if (cur_fall) begin
            hold_low_q <= 1'b1; // [R10]
            state_q <= SW_HOLD;
          end
        end
        SW_HOLD: begin
          if (new_rise) begin
            hold_low_q <= 1'b0;
            active_code_q <= target_q; // [R10]
            state_q <= SW_DONE;
          end
        end
        SW_DONE: begin
          done_q <= 1'b1;
          state_q <= SW_IDLE;
        end
        default: state_q <= SW_IDLE;
      endcase
    end
  end

  property p_same_src;
    @(posedge clk) disable iff (rst)
    (state_q == SW_IDLE && freq_req != active_code_q &&
     osccs_pkg::src_of(freq_req) == cur_src)
    |=> (active_code_q == $past(freq_req)) && done_q && !busy;
  endproperty
  a_same_src: assert property (p_same_src) // [R11]
    else $error("same-source switch not immediate");

  // Held low only in the hold state, so each cycle without a rise of the
  // new clock must keep the output low and the running code untouched
  property p_hold_until_rise;
    @(posedge clk) disable iff (rst)
    hold_low_q && !new_rise |=> hold_low_q && $stable(active_code_q);
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise) // [R10]
    else $error("clock released before new clock rise");

  property p_new_osc_on;
    @(posedge clk) disable iff (rst)
    (state_q == SW_START) |-> (new_src == osccs_pkg::OSCCS_SRC_HF ?
                               hf_en : lf_en);
  endproperty
  a_new_osc_on: assert property (p_new_osc_on) // [R10]
    else $error("new oscillator not started");

  property p_code_on_rise;
    @(posedge clk) disable iff (rst)
    $changed(active_code_q) && $past(state_q) == SW_HOLD |->
      $past(new_rise) && !hold_low_q ##1 done_q;
  endproperty
  a_code_on_rise: assert property (p_code_on_rise) // [R10]
    else $error("code changed without new clock rise");
endmodule

//--- verilog/osccs_regs.sv
// Oscillator control and status registers behind an AXI4-Lite slave.
// Assumes oscillator flags and sampled clock levels are synchronous to
// CLK_SYS; the analog oscillators and clock mux sit outside.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// R1: Freq code bits 6:3; 1111 is 16 MHz, halving down to 1011 (1 MHz).
// R2: Codes 1010, 1001, 1000 give 500/250/125 kHz from the fast oscillator.
// R3: Reset loads code 0111; lower codes divide on; 000x picks 31 kHz.
// R4: Clock select bits 1:0; 1x internal, 00 configuration source, 01 reserved.
// R5: Unimplemented control and status bits read as zero.
// R6: Status bit 4 shows the fast oscillator is ready.
// R7: Status bit 1 shows the slow oscillator is ready.
// R8: Status bit 0 set when 16 MHz is stable and driving the clock; here it mirrors HF_OSC_STABLE even while the slow oscillator drives the clock.
// R9: Every reset clears the clock select field.
// R10: Switch starts new clock, waits old fall, holds low, new rise, then status.
// R11: Switching within one oscillator source applies at once.
// R12: Writes to the status register are ignored.
module osccs_regs #(
  parameter int ADDR_W = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic HF_OSC_READY,
  input wire logic LF_OSC_READY,
  input wire logic HF_OSC_STABLE,
  input wire logic HF_CLK_LEVEL,
  input wire logic LF_CLK_LEVEL,
  output logic HF_OSC_ENABLE,
  output logic LF_OSC_ENABLE,
  output logic LF_SOURCE_ACTIVE,
  output logic [3:0] CLK_DIV_EXP,
  output logic CLK_HOLD_LOW,
  output logic SYS_CLK_INTERNAL,
  output logic IRQ
);
  osccs_pkg::osccs_ctrl_t ctrl_q;
  osccs_pkg::osccs_stat_t stat_q;
  logic [osccs_pkg::IRQ_W-1:0] irq_stat_q;
  logic [osccs_pkg::IRQ_W-1:0] irq_mask_q;
  logic [osccs_pkg::IRQ_W-1:0] irq_set;
  logic [osccs_pkg::IRQ_W-1:0] irq_clr;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic wr_fire;
  logic wr_lane0;
  logic [3:0] active_code;
  logic sw_busy;
  logic sw_hold;
  logic sw_done;
  logic [3:0] sys_div_q;
  logic lf_active_q;
  logic sys_int_q;
  // Folded at elaboration so the reset branch loads a plain constant
  localparam logic [3:0] DIV_RESET =
    osccs_pkg::div_exp(osccs_pkg::FREQ_RESET);

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == osccs_pkg::OFF_CTRL || a == osccs_pkg::OFF_STAT ||
           a == osccs_pkg::OFF_IRQ_STAT || a == osccs_pkg::OFF_IRQ_MASK;
  endfunction

  // Write channel: address and data are taken independently
  assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_have_q && !S_AXI_BVALID;
  assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wr_lane0 = wr_fire && wstrb_q[0];

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= osccs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= mapped(awaddr_q) ? osccs_pkg::RESP_OKAY :
                                        osccs_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Control register; reset loads 500 kHz and the configuration source
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q.freq <= osccs_pkg::FREQ_RESET; // [R3]
      ctrl_q.clk_sel <= osccs_pkg::CLKSEL_RESET; // [R9]
    end else if (wr_lane0 && awaddr_q == osccs_pkg::OFF_CTRL) begin
      // Bits 7 and 2 have no storage
      ctrl_q.freq <= wdata_q[osccs_pkg::FREQ_MSB:osccs_pkg::FREQ_LSB]; // [R1]
      ctrl_q.clk_sel <=
        wdata_q[osccs_pkg::CLKSEL_MSB:osccs_pkg::CLKSEL_LSB]; // [R4]
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_mask_q <= osccs_pkg::IRQ_RESET;
    end else if (wr_lane0 && awaddr_q == osccs_pkg::OFF_IRQ_MASK) begin
      irq_mask_q <= wdata_q[osccs_pkg::IRQ_W-1:0];
    end
  end

  // Status is frozen while a switch is in flight and refreshed after it
  // completes; writes to it have no effect.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stat_q <= '0;
    end else if (!sw_busy) begin
      stat_q.hf_ready <= HF_OSC_READY; // [R6] [R10] [R12]
      stat_q.lf_ready <= LF_OSC_READY; // [R7]
      stat_q.hf_stable <= HF_OSC_STABLE; // [R8]
    end
  end

  assign irq_set[osccs_pkg::IRQ_DONE] = sw_done;
  assign irq_set[osccs_pkg::IRQ_HF] = !sw_busy &&
                                      (stat_q.hf_ready != HF_OSC_READY);
  assign irq_set[osccs_pkg::IRQ_LF] = !sw_busy &&
                                      (stat_q.lf_ready != LF_OSC_READY);
  assign irq_clr = (wr_lane0 && awaddr_q == osccs_pkg::OFF_IRQ_STAT) ?
                   wdata_q[osccs_pkg::IRQ_W-1:0] : osccs_pkg::IRQ_RESET;

  // A set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_stat_q <= osccs_pkg::IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // Read channel: one cycle from address to data
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= osccs_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? osccs_pkg::RESP_OKAY :
                                            osccs_pkg::RESP_SLVERR;
      case (S_AXI_ARADDR)
        osccs_pkg::OFF_CTRL:
          S_AXI_RDATA <= {24'h00_0000, osccs_pkg::ctrl_byte(ctrl_q)}; // [R5]
        osccs_pkg::OFF_STAT:
          S_AXI_RDATA <= {24'h00_0000, osccs_pkg::stat_byte(stat_q)}; // [R5]
        osccs_pkg::OFF_IRQ_STAT:
          S_AXI_RDATA <= {29'h0000_0000, irq_stat_q};
        osccs_pkg::OFF_IRQ_MASK:
          S_AXI_RDATA <= {29'h0000_0000, irq_mask_q};
        default: S_AXI_RDATA <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  osccs_switch u_switch (
    .clk(CLK_SYS),
    .rst(RST),
    .freq_req(ctrl_q.freq),
    .hf_rdy(HF_OSC_READY),
    .lf_rdy(LF_OSC_READY),
    .hf_lvl(HF_CLK_LEVEL),
    .lf_lvl(LF_CLK_LEVEL),
    .active_code_q(active_code),
    .busy(sw_busy),
    .hold_low_q(sw_hold),
    .done_q(sw_done),
    .hf_en(HF_OSC_ENABLE),
    .lf_en(LF_OSC_ENABLE)
  );

  // Clock path outputs follow the code that is actually running, except SYS_CLK_INTERNAL, which follows the clock select field
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sys_div_q <= DIV_RESET;
      lf_active_q <= 1'b0;
      sys_int_q <= 1'b0;
    end else begin
      sys_div_q <= osccs_pkg::div_exp(active_code); // [R1] [R2] [R3]
      lf_active_q <= osccs_pkg::src_of(active_code) ==
                     osccs_pkg::OSCCS_SRC_LF; // [R3]
      // 01 has no secondary oscillator here and falls back to 00
      sys_int_q <= ctrl_q.clk_sel[osccs_pkg::CLKSEL_MSB]; // [R4]
    end
  end

  assign CLK_DIV_EXP = sys_div_q;
  assign LF_SOURCE_ACTIVE = lf_active_q;
  assign CLK_HOLD_LOW = sw_hold;
  assign SYS_CLK_INTERNAL = sys_int_q;

  property p_reset_ctrl;
    @(posedge CLK_SYS) $fell(RST) |->
      ctrl_q.clk_sel == osccs_pkg::CLKSEL_RESET &&
      ctrl_q.freq == osccs_pkg::FREQ_RESET;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) // [R9]
    else $error("control not at reset value");

  property p_reserved_zero;
    @(posedge CLK_SYS) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY &&
      (S_AXI_ARADDR == osccs_pkg::OFF_CTRL ||
       S_AXI_ARADDR == osccs_pkg::OFF_STAT) |=>
      S_AXI_RDATA[31:8] == 24'h00_0000 && !S_AXI_RDATA[7] &&
      !S_AXI_RDATA[2] && ($past(S_AXI_ARADDR) == osccs_pkg::OFF_CTRL ||
      (S_AXI_RDATA[6:5] == 2'h0 && !S_AXI_RDATA[3]));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R5]
    else $error("reserved bit reads nonzero");

  property p_status_ignores_write;
    @(posedge CLK_SYS) disable iff (RST)
    wr_fire && awaddr_q == osccs_pkg::OFF_STAT && !sw_busy |=>
      stat_q == {$past(HF_OSC_READY), $past(LF_OSC_READY),
                 $past(HF_OSC_STABLE)};
  endproperty
  a_status_ignores_write: assert property (p_status_ignores_write) // [R12]
    else $error("status changed by write");

  property p_hf_ready_bit;
    @(posedge CLK_SYS) disable iff (RST)
    !sw_busy |=> stat_q.hf_ready == $past(HF_OSC_READY) &&
      stat_q.lf_ready == $past(LF_OSC_READY);
  endproperty
  a_hf_ready_bit: assert property (p_hf_ready_bit) // [R6] [R7]
    else $error("ready bits do not follow oscillator");

  property p_stable_bit;
    @(posedge CLK_SYS) disable iff (RST)
    !sw_busy ##1 S_AXI_ARVALID && S_AXI_ARREADY &&
      S_AXI_ARADDR == osccs_pkg::OFF_STAT |=>
      S_AXI_RDATA[0] == $past(stat_q.hf_stable) &&
      S_AXI_RDATA[4] == $past(stat_q.hf_ready);
  endproperty
  a_stable_bit: assert property (p_stable_bit) // [R8]
    else $error("status read mismatch");

  property p_freq_decode;
    @(posedge CLK_SYS) disable iff (RST)
    active_code == 4'hF ##1 active_code == 4'hF |->
      CLK_DIV_EXP == 4'h0 && !LF_SOURCE_ACTIVE;
  endproperty
  a_freq_decode: assert property (p_freq_decode) // [R1]
    else $error("16 MHz code decoded wrongly");

  property p_clksel_decode;
    @(posedge CLK_SYS) disable iff (RST)
    1'b1 |=> SYS_CLK_INTERNAL ==
      $past(ctrl_q.clk_sel[osccs_pkg::CLKSEL_MSB]);
  endproperty
  a_clksel_decode: assert property (p_clksel_decode) // [R4]
    else $error("clock select decoded wrongly");

  property p_status_frozen;
    @(posedge CLK_SYS) disable iff (RST)
    sw_busy && $past(sw_busy) |-> stat_q == $past(stat_q);
  endproperty
  a_status_frozen: assert property (p_status_frozen) // [R10]
    else $error("status moved during switch");
endmodule

//--- sim/osccs_tb.sv
// Self-checking bench for the oscillator control and status registers.
// Assumes osccs_regs as the only design; the bench is the AXI4-Lite master
// and stands in for the oscillators, whose clock levels toggle freely.
`timescale 1ns/10ps
module testbench;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] awaddr = 5'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic [4:0] araddr = 5'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic hf_rdy = 1'b1;
  logic lf_rdy = 1'b0;
  logic hf_stb = 1'b1;
  logic hf_lvl = 1'b0;
  logic lf_lvl = 1'b0;
  logic hf_en;
  logic lf_en;
  logic lf_act;
  logic [3:0] div_exp;
  logic hold_low;
  logic sys_int;
  logic irq;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Divide exponent expected for each HF-derived code
  logic [3:0] exp_div [2:15] = '{4'h9, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5,
    4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};

  // Ready lines tied high: the master never stalls a response
  osccs_regs #(.ADDR_W(5)) DUT (
    .CLK_SYS(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(1'b1), .HF_OSC_READY(hf_rdy), .LF_OSC_READY(lf_rdy),
    .HF_OSC_STABLE(hf_stb), .HF_CLK_LEVEL(hf_lvl), .LF_CLK_LEVEL(lf_lvl),
    .HF_OSC_ENABLE(hf_en), .LF_OSC_ENABLE(lf_en),
    .LF_SOURCE_ACTIVE(lf_act), .CLK_DIV_EXP(div_exp),
    .CLK_HOLD_LOW(hold_low), .SYS_CLK_INTERNAL(sys_int), .IRQ(irq)
  );

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    hf_lvl <= ~hf_lvl;
    if (cycles % 4 == 0) begin
      lf_lvl <= ~lf_lvl;
    end
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("[ERR] %0t run took too long", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ends on BVALID; with no timeout of its own, only the bench timeout ends a hang
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wrc(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk(32'(r), 32'h0000_0000, "write response");
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(32'(r), 32'h0000_0000, "read response");
    chk(d, exp, "read data");
  endtask

  task automatic t_reset;
    rdc(5'h00, 32'h0000_0038);
    rdc(5'h04, 32'h0000_0011);
    chk(32'(div_exp), 32'h0000_0005, "reset divide");
    chk(32'(sys_int), 32'h0000_0000, "reset select");
    $display("t_reset done");
  endtask

  task automatic t_ctrl;
    logic [1:0] r;
    wrc(5'h00, 32'hFFFF_FFFF);
    rdc(5'h00, 32'h0000_007B);
    // Strobe off must leave the register alone
    wr(5'h00, 32'h0000_0000, 4'h0, r);
    rdc(5'h00, 32'h0000_007B);
    for (int s = 0; s < 4; s++) begin
      wrc(5'h00, 32'(8'h78 | s));
      repeat (2) @(posedge clk);
      chk(32'(sys_int), 32'(s >> 1), "clock select");
    end
    $display("t_ctrl done");
  endtask

  task automatic t_codes;
    for (int c = 15; c >= 2; c--) begin
      wrc(5'h00, 32'((c << 3) | 2));
      repeat (3) @(posedge clk);
      chk(32'(div_exp), 32'(exp_div[c]), "divide");
      chk(32'(lf_act), 32'h0000_0000, "source");
    end
    $display("t_codes done");
  endtask

  task automatic t_status;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) begin
      hf_rdy <= i[2];
      lf_rdy <= i[1];
      hf_stb <= i[0];
      repeat (3) @(posedge clk);
      e = {27'h0, i[2], 2'h0, i[1], i[0]};
      rdc(5'h04, e);
    end
    wrc(5'h04, 32'h0000_00FF);
    rdc(5'h04, 32'h0000_0013);
    $display("t_status done");
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(5'h10, 32'h0000_00FF, 4'hF, r);
    chk(32'(r), 32'h0000_0002, "unmapped write");
    rd(5'h10, d, r);
    chk(32'(r), 32'h0000_0002, "unmapped read");
    chk(d, 32'h0000_0000, "unmapped data");
    $display("t_unmapped done");
  endtask

  task automatic t_switch;
    int n;
    int seen;
    logic [31:0] d;
    logic [1:0] r;
    lf_rdy <= 1'b0;
    wrc(5'h08, 32'h0000_0007);
    wrc(5'h0C, 32'h0000_0000);
    wrc(5'h00, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk(32'(lf_en), 32'h0000_0001, "slow osc enable");
    repeat (10) @(posedge clk);
    chk(32'(lf_act), 32'h0000_0000, "early switch");
    lf_rdy <= 1'b1;
    n = 0;
    seen = 0;
    while (lf_act !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      if (hold_low === 1'b1) seen = 1;
    end
    chk(32'(seen), 32'h0000_0001, "hold low seen");
    chk(32'(lf_act), 32'h0000_0001, "slow source active");
    chk(32'(hold_low), 32'h0000_0000, "hold released");
    chk(32'(hf_en), 32'h0000_0000, "fast osc off");
    repeat (3) @(posedge clk);
    rdc(5'h04, 32'h0000_0013);
    rd(5'h08, d, r);
    chk(d, 32'h0000_0005, "switch and slow ready flags");
    chk(32'(irq), 32'h0000_0000, "masked irq");
    wrc(5'h0C, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001, "unmasked irq");
    wrc(5'h08, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000, "cleared irq");
    wrc(5'h00, 32'h0000_007A);
    n = 0;
    while (lf_act !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(32'(div_exp), 32'h0000_0000, "back to fast");
    chk(32'(hf_en), 32'h0000_0001, "fast osc on");
    chk(32'(lf_en), 32'h0000_0000, "slow osc off");
    $display("t_switch done");
  endtask

  task automatic t_reset2;
    wrc(5'h00, 32'h0000_007B);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(5'h00, 32'h0000_0038);
    chk(32'(irq), 32'h0000_0000, "irq after reset");
    $display("t_reset2 done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ctrl();
    t_codes();
    t_status();
    t_unmapped();
    t_switch();
    t_reset2();
    tally_and_finish();
  end
endmodule
